//--- design/hsp_protect_ctrl.sv
// High-side switch protection control register and fault decisions
// Functional notes
// - Per-switch overvoltage restore bit: resume prior state, else stay off.
// - Overtemperature bit 0 turns off all switches, 1 only the hot one.
// - Normal mode: per-switch bit 0 cuts on overvoltage, 1 suppresses.
// - Stop or sleep mode: one common bit governs overvoltage cutoff.
// - Undervolt bit 0 turns switches off during supply undervoltage.
// - Common undervoltage restore bit resumes prior state when set.
// - Bits 4 and 2:0 unused, ignore writes, read zero.
// - Power-on or soft reset clears the whole register.
// - Restart keeps writable bits; unused bits read zero.
`timescale 1ns/100ps
module hsp_protect_ctrl
   import hsp_pkg::*;
#(
   parameter int N = NSW
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic soft_rst,
   input wire logic restart,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire hsp_mode_e mode,
   input wire logic [3:0] sw_cmd_on,
   input wire logic ov_pin,
   input wire logic uv_pin,
   input wire logic [3:0] ot_pin,
   output logic [3:0] sw_on
);
   typedef struct packed {
      logic [15:0] ctrl;
      hsp_fault_s s1;
      hsp_fault_s s2;
   } hsp_state_s;
   hsp_state_s st, next_st;
   hsp_cfg_s cfg;
   logic [3:0] ov_cut, ov_rest, ot_cut;
   logic uv_cut;

   ////////////////////////////////////////////////////////////////////
   // Register and fault synchronisers
   always_comb begin
      next_st = st;
      next_st.s1 = {ov_pin, uv_pin, ot_pin};
      next_st.s2 = st.s1;
      if (soft_rst) begin
         next_st.ctrl = REG_RESET;
      end else if (reg_wr) begin
         next_st.ctrl = reg_wdata & REG_WMASK;
      end
      // Restart leaves ctrl untouched
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.ctrl & REG_WMASK;

   ////////////////////////////////////////////////////////////////////
   // Field decode and fault decisions
   assign cfg.ov_restore = st.ctrl[F_OV_RESTORE_LO +: 4];
   assign cfg.ot_group = st.ctrl[F_OT_GROUP];
   assign cfg.ov_cut_off = st.ctrl[F_OV_CUT_LO +: 4];
   assign cfg.lp_ov_cut_off = st.ctrl[F_LP_OV_CUT];
   assign cfg.uv_cut_off = st.ctrl[F_UV_CUT];
   assign cfg.uv_restore = st.ctrl[F_UV_RESTORE];

   assign uv_cut = st.s2.uv && !cfg.uv_cut_off;

   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (mode == HSP_NORMAL) begin
            ov_cut[i] = st.s2.ov && !cfg.ov_cut_off[i];
         end else begin
            ov_cut[i] = st.s2.ov && !cfg.lp_ov_cut_off;
         end
         ov_rest[i] = cfg.ov_restore[i];
         if (cfg.ot_group) begin
            ot_cut[i] = st.s2.ot[i];
         end else begin
            ot_cut[i] = |st.s2.ot;
         end
      end
   end

   for (genvar g = 0; g < N; g++) begin : g_sw
      hsp_switch_gate u_gate (
         .core_clk(core_clk),
         .rst(rst),
         .cmd_on(sw_cmd_on[g]),
         .ov_cut(ov_cut[g]),
         .ov_rest(ov_rest[g]),
         .uv_cut(uv_cut),
         .uv_rest(cfg.uv_restore),
         .ot_cut(ot_cut[g]),
         .sw_on(sw_on[g])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // Register checks
   unused_zero_a: assert property (
      @(posedge core_clk) disable iff (rst)
      reg_rdata[4] == 1'b0 && reg_rdata[2:0] == 3'h0)
      else $error("Unused bits not zero");

   soft_clear_a: assert property (
      @(posedge core_clk) disable iff (rst)
      soft_rst |=> reg_rdata == REG_RESET)
      else $error("Soft reset did not clear");

   restart_keep_a: assert property (
      @(posedge core_clk) disable iff (rst)
      restart && !soft_rst && !reg_wr |=> $stable(reg_rdata))
      else $error("Restart changed register");

   write_take_a: assert property (
      @(posedge core_clk) disable iff (rst)
      reg_wr && !soft_rst
      |=> reg_rdata == ($past(reg_wdata) & REG_WMASK))
      else $error("Write not stored");

   ////////////////////////////////////////////////////////////////////
   // Overtemperature checks
   ot_group_a: assert property (
      @(posedge core_clk) disable iff (rst)
      st.s2.ot != 4'h0 && !cfg.ot_group
      |=> sw_on == 4'h0)
      else $error("Grouped overtemp left a switch on");

   ot_single_a: assert property (
      @(posedge core_clk) disable iff (rst)
      cfg.ot_group && st.s2.ot[0] |=> !sw_on[0])
      else $error("Individual overtemp left hot switch on");

   ot_spare_a: assert property (
      @(posedge core_clk) disable iff (rst)
      cfg.ot_group && !st.s2.ot[1] && !ov_cut[1] && !uv_cut
      && sw_cmd_on[1] && sw_on[1] |=> sw_on[1])
      else $error("Individual overtemp cut a cool switch");

   ////////////////////////////////////////////////////////////////////
   // Overvoltage checks
   ov_normal_a: assert property (
      @(posedge core_clk) disable iff (rst)
      mode == HSP_NORMAL && st.s2.ov && !cfg.ov_cut_off[0]
      |=> !sw_on[0])
      else $error("Normal overvoltage cut missed");

   ov_second_a: assert property (
      @(posedge core_clk) disable iff (rst)
      mode == HSP_NORMAL && st.s2.ov && !cfg.ov_cut_off[1]
      |=> !sw_on[1])
      else $error("Normal overvoltage cut missed on second");

   ov_third_a: assert property (
      @(posedge core_clk) disable iff (rst)
      mode == HSP_NORMAL && st.s2.ov && !cfg.ov_cut_off[2]
      |=> !sw_on[2])
      else $error("Normal overvoltage cut missed on third");

   ov_fourth_a: assert property (
      @(posedge core_clk) disable iff (rst)
      mode == HSP_NORMAL && st.s2.ov && !cfg.ov_cut_off[3]
      |=> !sw_on[3])
      else $error("Normal overvoltage cut missed on fourth");

   ov_suppress_a: assert property (
      @(posedge core_clk) disable iff (rst)
      mode == HSP_NORMAL && st.s2.ov && cfg.ov_cut_off[0] && !uv_cut
      && !ot_cut[0] && sw_cmd_on[0] && sw_on[0] |=> sw_on[0])
      else $error("Normal overvoltage cut not suppressed");

   ov_lowpwr_a: assert property (
      @(posedge core_clk) disable iff (rst)
      mode != HSP_NORMAL && st.s2.ov && !cfg.lp_ov_cut_off
      |=> sw_on == 4'h0)
      else $error("Low power overvoltage cut missed");

   lp_suppress_a: assert property (
      @(posedge core_clk) disable iff (rst)
      mode != HSP_NORMAL && st.s2.ov && cfg.lp_ov_cut_off && !uv_cut
      && !ot_cut[2] && sw_cmd_on[2] && sw_on[2] |=> sw_on[2])
      else $error("Low power overvoltage cut not suppressed");

   ov_hold_a: assert property (
      @(posedge core_clk) disable iff (rst)
      ov_cut[1] && !ov_rest[1] && sw_cmd_on[1] ##1 sw_cmd_on[1]
      |=> !sw_on[1])
      else $error("Overvoltage lockout released early");

   ////////////////////////////////////////////////////////////////////
   // Undervoltage checks
   uv_cut_a: assert property (
      @(posedge core_clk) disable iff (rst)
      st.s2.uv && !cfg.uv_cut_off |=> sw_on == 4'h0)
      else $error("Undervoltage cut missed");

   uv_keep_a: assert property (
      @(posedge core_clk) disable iff (rst)
      cfg.uv_cut_off && !st.s2.ov && st.s2.ot == 4'h0
      && sw_cmd_on[1] && sw_on[1] |=> sw_on[1])
      else $error("Undervoltage suppressed but switch off");

   uv_keep_lo_a: assert property (
      @(posedge core_clk) disable iff (rst)
      cfg.uv_cut_off && st.s2.uv && !st.s2.ov && st.s2.ot == 4'h0
      && sw_cmd_on[0] && sw_on[0] |=> sw_on[0])
      else $error("Undervoltage suppressed but first switch off");

   uv_hold_a: assert property (
      @(posedge core_clk) disable iff (rst)
      uv_cut && !cfg.uv_restore && sw_cmd_on[3] ##1 sw_cmd_on[3]
      |=> !sw_on[3])
      else $error("Undervoltage lockout released early");
endmodule // hsp_protect_ctrl

//--- design/hsp_switch_gate.sv
// Per-switch fault latch and gating
`timescale 1ns/100ps
module hsp_switch_gate
   import hsp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cmd_on,
   input wire logic ov_cut,
   input wire logic ov_rest,
   input wire logic uv_cut,
   input wire logic uv_rest,
   input wire logic ot_cut,
   output logic sw_on
);
   typedef struct packed {
      logic ov_lock;
      logic uv_lock;
      logic on;
   } hsp_gate_s;
   hsp_gate_s st, next_st;

   always_comb begin
      next_st = st;
      // Locks drop once the switch is commanded off
      if (!cmd_on) begin
         next_st.ov_lock = 1'b0;
         next_st.uv_lock = 1'b0;
      end
      // Fault without restore locks the switch; set wins
      if (ov_cut && !ov_rest) begin
         next_st.ov_lock = 1'b1;
      end
      if (uv_cut && !uv_rest) begin
         next_st.uv_lock = 1'b1;
      end
      next_st.on = cmd_on && !ov_cut && !uv_cut && !ot_cut
         && !next_st.ov_lock && !next_st.uv_lock;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sw_on = st.on;

   ovlock_off_a: assert property (
      @(posedge core_clk) disable iff (rst)
      st.ov_lock && cmd_on |=> !sw_on)
      else $error("Locked switch is on");

   uvlock_off_a: assert property (
      @(posedge core_clk) disable iff (rst)
      st.uv_lock && cmd_on |=> !sw_on)
      else $error("Undervoltage locked switch is on");

   ov_resume_a: assert property (
      @(posedge core_clk) disable iff (rst)
      ov_cut && ov_rest && !st.ov_lock |=> !st.ov_lock)
      else $error("Restore set but overvoltage locked");

   uv_resume_a: assert property (
      @(posedge core_clk) disable iff (rst)
      uv_cut && uv_rest && !st.uv_lock |=> !st.uv_lock)
      else $error("Restore set but undervoltage locked");

   resume_on_a: assert property (
      @(posedge core_clk) disable iff (rst)
      cmd_on && !ov_cut && !uv_cut && !ot_cut && !st.ov_lock
      && !st.uv_lock |=> sw_on)
      else $error("Switch not back on after faults");
endmodule // hsp_switch_gate

//--- shared/hsp_pkg.sv
// Package for the high-side switch protection controller
package hsp_pkg;
   localparam int NSW = 4;
   localparam int REG_W = 16;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] REG_WMASK = 16'hFFE8;
   localparam int F_OV_RESTORE_LO = 12;
   localparam int F_OT_GROUP = 11;
   localparam int F_OV_CUT_LO = 7;
   localparam int F_LP_OV_CUT = 6;
   localparam int F_UV_CUT = 5;
   localparam int F_UV_RESTORE = 3;

   typedef enum logic [1:0] {HSP_NORMAL, HSP_STOP, HSP_SLEEP} hsp_mode_e;

   typedef struct packed {
      logic [3:0] ov_restore;
      logic ot_group;
      logic [3:0] ov_cut_off;
      logic lp_ov_cut_off;
      logic uv_cut_off;
      logic uv_restore;
   } hsp_cfg_s;

   typedef struct packed {
      logic ov;
      logic uv;
      logic [3:0] ot;
   } hsp_fault_s;
endpackage

//--- tb/hsp_host.sv
// Host model writing the protection register
`timescale 1ns/100ps
module hsp_host (
   input wire logic core_clk,
   output logic reg_wr,
   output logic [15:0] reg_wdata,
   output logic soft_rst
);
   initial begin
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      soft_rst = 1'b0;
   end
   // One-cycle write; data inverted once released
   task automatic wr(input logic [15:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   task automatic srst();
      @(negedge core_clk);
      soft_rst = 1'b1;
      @(negedge core_clk);
      soft_rst = 1'b0;
   endtask
endmodule // hsp_host

//--- tb/tb_high_side_protection_ctrl.sv
// Testbench for the protection controller
`timescale 1ns/100ps
module tb_high_side_protection_ctrl
   import hsp_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic restart = 1'b0;
   logic reg_wr, soft_rst;
   logic [15:0] reg_wdata, reg_rdata;
   hsp_mode_e mode = HSP_NORMAL;
   logic [3:0] sw_cmd_on = 4'h0;
   logic ov_pin = 1'b0;
   logic uv_pin = 1'b0;
   logic [3:0] ot_pin = 4'h0;
   logic [3:0] sw_on;
   int n_fail = 0;
   int checked = 0;
   always #50 core_clk = ~core_clk;
   hsp_host host (.core_clk(core_clk), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .soft_rst(soft_rst));
   hsp_protect_ctrl dut (.core_clk(core_clk), .rst(rst),
      .soft_rst(soft_rst), .restart(restart), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mode(mode),
      .sw_cmd_on(sw_cmd_on), .ov_pin(ov_pin), .uv_pin(uv_pin),
      .ot_pin(ot_pin), .sw_on(sw_on));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Configure, raise faults, check during and after
   task automatic fault(input logic [15:0] cfg, input hsp_mode_e m,
      input logic [5:0] f, input logic [3:0] e_in, input logic [3:0] e_out);
      host.wr(cfg);
      mode = m;
      sw_cmd_on = 4'h0;
      wait_n(4);
      sw_cmd_on = 4'hF;
      wait_n(4);
      {ov_pin, uv_pin, ot_pin} = f;
      wait_n(4);
      chk(16'(sw_on), 16'(e_in));
      {ov_pin, uv_pin, ot_pin} = 6'h00;
      wait_n(4);
      chk(16'(sw_on), 16'(e_out));
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reg();
      chk(reg_rdata, 16'h0000);
      host.wr(16'hFFFF);
      chk(reg_rdata, 16'hFFE8);
      restart = 1'b1;
      wait_n(3);
      chk(reg_rdata, 16'hFFE8);
      restart = 1'b0;
      host.srst();
      chk(reg_rdata, 16'h0000);
      host.wr(16'hFFFF);
      chk(reg_rdata, 16'hFFE8);
      rst = 1'b1;
      wait_n(2);
      chk(reg_rdata, 16'h0000);
      rst = 1'b0;
      wait_n(2);
      chk(reg_rdata, 16'h0000);
   endtask
   task automatic t_ov();
      fault(16'h5000, HSP_NORMAL, 6'h20, 4'h0, 4'h5);
      fault(16'h0180, HSP_NORMAL, 6'h20, 4'h3, 4'h3);
      fault(16'h0040, HSP_STOP, 6'h20, 4'hF, 4'hF);
      fault(16'h0780, HSP_SLEEP, 6'h20, 4'h0, 4'h0);
   endtask
   task automatic t_uv();
      fault(16'h0008, HSP_NORMAL, 6'h10, 4'h0, 4'hF);
      fault(16'h0000, HSP_NORMAL, 6'h10, 4'h0, 4'h0);
      fault(16'h0020, HSP_NORMAL, 6'h10, 4'hF, 4'hF);
   endtask
   task automatic t_ot();
      fault(16'h0000, HSP_NORMAL, 6'h01, 4'h0, 4'hF);
      fault(16'h0800, HSP_NORMAL, 6'h01, 4'hE, 4'hF);
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (5000) @(negedge core_clk);
      n_fail++;
      $display("BAD %0t run limit reached", $time);
      stop_test();
   end
   initial begin
      wait_n(4);
      rst = 1'b0;
      wait_n(1);
      t_reg();
      t_ov();
      t_uv();
      t_ot();
      stop_test();
   end
endmodule // tb_high_side_protection_ctrl
